// ### lpbcs_pkg.sv
// Package for the low-power DRAM bank command and state block.
// Assumes a 125 MHz core clock and a classic Wishbone register port.
package lpbcs_pkg;

   // ****************************************
   // Geometry
   // ****************************************
   localparam int BANKS = 4;
   localparam int ROW_W = 2;
   localparam int COL_W = 4;
   localparam int ADDR_W = 13;
   localparam int DQ_W = 16;
   localparam int IDX_W = 2 + ROW_W + COL_W;
   localparam int DEPTH = 1 << IDX_W;
   localparam int AP_BIT = 10;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_MHZ = 125;
   localparam int T_RP_NS = 18;
   localparam int T_RCD_NS = 18;
   localparam int T_RFC_NS = 72;
   localparam int T_MRD_NS = 10;
   localparam int T_WR_NS = 15;
   localparam logic [3:0] RP_CYC = 4'((T_RP_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RCD_CYC = 4'((T_RCD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] RFC_CYC = 4'((T_RFC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] MRD_CYC = 4'((T_MRD_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WR_CYC = 4'((T_WR_NS * CLK_MHZ + 999) / 1000);
   localparam logic [3:0] WR_RP_CYC = 4'(WR_CYC + RP_CYC);

   // ****************************************
   // Registers
   // ****************************************
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STAT = 8'h04;
   localparam logic [7:0] REG_REFCNT = 8'h08;
   localparam logic [1:0] BL_CODE_RST = 2'h1;
   localparam int STAT_MODE_LSB = 12;
   localparam int STAT_BURST_BIT = 15;

   // ****************************************
   // Types
   // ****************************************
   typedef enum logic [3:0] {
      CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_BT, CMD_PRE,
      CMD_REF, CMD_LMR, CMD_SREF, CMD_DEEP
   } lpbcs_cmd_e;

   typedef enum logic [2:0] {
      BK_IDLE, BK_ACTG, BK_OPEN, BK_READ, BK_WRITE, BK_PRE
   } lpbcs_bank_e;

   typedef enum logic [2:0] {
      MD_RUN, MD_BUSY, MD_SELF, MD_DEEP
   } lpbcs_mode_e;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic cke;
      logic [1:0] ba;
      logic [ADDR_W-1:0] addr;
      logic [1:0] dm;
      logic [DQ_W-1:0] dq;
   } lpbcs_pins_s;

   localparam lpbcs_pins_s PINS_IDLE = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1,
      we_n: 1'b1, default: '0};

   typedef struct packed {
      logic act;
      logic rd;
      logic wr;
      logic pre;
      logic ap;
      logic done;
      logic clear;
   } lpbcs_bank_cmd_s;

endpackage

// ### lpbcs_bank.sv
// One bank's state machine: idle, activating, open, read, write, precharge.
// Assumes the caller gates commands that the bank must not receive.
`timescale 1ns/1ps
`default_nettype none
module lpbcs_bank import lpbcs_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Commands for this bank
   input wire lpbcs_bank_cmd_s cmd_i,
   input wire logic [ROW_W-1:0] row_i,
   // State
   output var lpbcs_bank_e state_o,
   output var logic [ROW_W-1:0] row_o,
   output var logic col_ok_o
);

   lpbcs_bank_e state_ff, nxt_state;
   logic [3:0] cnt_ff, nxt_cnt;
   logic ap_ff, nxt_ap;
   logic [ROW_W-1:0] row_ff, nxt_row;

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_ap = ap_ff;
      nxt_row = row_ff;
      case (state_ff)
         BK_IDLE: begin
            if (cmd_i.act) begin
               nxt_state = BK_ACTG;
               nxt_cnt = RCD_CYC;
               nxt_row = row_i;
            end
         end
         BK_ACTG, BK_PRE: begin
            if (cnt_ff <= 4'h1) begin
               nxt_state = (state_ff == BK_ACTG) ? BK_OPEN : BK_IDLE;
            end else begin
               nxt_cnt = cnt_ff - 4'h1;
            end
         end
         BK_OPEN, BK_READ, BK_WRITE: begin
            if (cmd_i.done) begin
               nxt_state = ap_ff ? BK_PRE : BK_OPEN;
               nxt_cnt = (state_ff == BK_WRITE) ? WR_RP_CYC : RP_CYC;
               nxt_ap = 1'b0;
            end
            if (cmd_i.rd || cmd_i.wr) begin
               nxt_state = cmd_i.rd ? BK_READ : BK_WRITE;
               nxt_ap = cmd_i.ap;
            end else if (cmd_i.pre) begin
               nxt_state = BK_PRE;
               nxt_cnt = RP_CYC;
               nxt_ap = 1'b0;
            end
         end
         default: nxt_state = BK_IDLE;
      endcase
      if (cmd_i.clear) begin
         nxt_state = BK_IDLE;
         nxt_ap = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff <= BK_IDLE;
         cnt_ff <= 4'h0;
         ap_ff <= 1'b0;
         row_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         ap_ff <= nxt_ap;
         row_ff <= nxt_row;
      end
   end

   assign state_o = state_ff;
   assign row_o = row_ff;
   // Auto-close bursts must not be interrupted on the same bank
   assign col_ok_o = (state_ff == BK_OPEN) ||
      (((state_ff == BK_READ) || (state_ff == BK_WRITE)) && !ap_ff);

endmodule
`default_nettype wire

// ### lpbcs_top.sv
// Command decoder, bank states, burst engine and array of a four-bank LPDRAM.
// Assumes pins are asynchronous to clk_i and a classic Wishbone master.
//
// Function
// - READ takes bank from bank select, column from low address, starts read burst.
// - WRITE takes bank and column likewise, starts a write burst storing data.
// - A10 with READ or WRITE selects closing the row when the burst ends.
// - A byte is written only when its mask is low with the data.
// - PRECHARGE with A10 high closes all banks, else only the selected bank.
// - BURST TERMINATE cuts latest read without auto close; its row stays open.
// - AUTO REFRESH uses internal row counter, ignores address, busy for refresh time.
// - SELF REFRESH is refresh with clock enable low; all else ignored.
// - Terminate encoding with clock enable low enters deepest power saving; data lost.
// - Chip select high or pattern LHHH is no-operation; operations continue.
// - Idle bank takes ACTIVE; refresh and mode load need all banks idle.
// - Open or reading bank takes READ, WRITE, PRECHARGE; reads take terminate.
// - Writing bank takes WRITE, READ or truncating PRECHARGE.
// - Banks leave precharge and activate after their times; auto-close returns idle.
// - Refresh, mode load and precharge-all block commands until their times pass.
// - Commands count only with clock enable high on previous edge and high on current edge, low for self refresh and deep power saving.
// - Device drives data strobe on reads, edge aligned with data.
// - Burst length programmable to two, four, eight or sixteen words.
`timescale 1ns/1ps
`default_nettype none
module lpbcs_top import lpbcs_pkg::*; (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Memory command pins
   input wire logic mem_cs_n_i,
   input wire logic mem_ras_n_i,
   input wire logic mem_cas_n_i,
   input wire logic mem_we_n_i,
   input wire logic mem_cke_i,
   input wire logic [1:0] mem_ba_i,
   input wire logic [ADDR_W-1:0] mem_addr_i,
   // Data pins
   input wire logic [1:0] mem_dm_i,
   input wire logic [DQ_W-1:0] mem_dq_i,
   output logic [DQ_W-1:0] mem_dq_o,
   output logic mem_dq_oe_o,
   output logic mem_dqs_o,
   output logic mem_dqs_oe_o
);

   // ****************************************
   // Pin synchroniser
   // ****************************************
   lpbcs_pins_s pin_in, pin_meta_ff, pin_ff;
   logic cke_prev_ff;

   assign pin_in = {mem_cs_n_i, mem_ras_n_i, mem_cas_n_i, mem_we_n_i, mem_cke_i,
      mem_ba_i, mem_addr_i, mem_dm_i, mem_dq_i};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_meta_ff <= PINS_IDLE;
         pin_ff <= PINS_IDLE;
         cke_prev_ff <= 1'b0;
      end else begin
         pin_meta_ff <= pin_in;
         pin_ff <= pin_meta_ff;
         cke_prev_ff <= pin_ff.cke;
      end
   end

   // ****************************************
   // Command decode
   // ****************************************
   lpbcs_cmd_e cmd;
   lpbcs_mode_e md_ff, nxt_md;
   logic acc;
   logic acc_low;

   always_comb begin
      cmd = CMD_NOP;
      if (!pin_ff.cs_n) begin
         case ({pin_ff.ras_n, pin_ff.cas_n, pin_ff.we_n})
            3'b011: cmd = CMD_ACT;
            3'b101: cmd = CMD_RD;
            3'b100: cmd = CMD_WR;
            3'b110: cmd = pin_ff.cke ? CMD_BT : CMD_DEEP;
            3'b010: cmd = CMD_PRE;
            3'b001: cmd = pin_ff.cke ? CMD_REF : CMD_SREF;
            3'b000: cmd = CMD_LMR;
            default: cmd = CMD_NOP;
         endcase
      end
   end

   // Only a running device with clock enable held high takes bank commands
   assign acc = (md_ff == MD_RUN) && cke_prev_ff && pin_ff.cke;
   assign acc_low = (md_ff == MD_RUN) && cke_prev_ff && !pin_ff.cke;

   // ****************************************
   // Banks
   // ****************************************
   lpbcs_bank_cmd_s bcmd [BANKS];
   lpbcs_bank_e bk_state [BANKS];
   logic [ROW_W-1:0] bk_row [BANKS];
   logic [BANKS-1:0] bk_col_ok;
   logic [BANKS-1:0] bk_idle;
   logic [BANKS-1:0] bst_done;
   logic all_idle;
   logic col_go;
   logic bt_go;
   logic dpd_go;

   assign col_go = acc && ((cmd == CMD_RD) || (cmd == CMD_WR)) && bk_col_ok[pin_ff.ba];
   assign all_idle = &bk_idle;
   assign dpd_go = acc_low && (cmd == CMD_DEEP) && all_idle;

   for (genvar b = 0; b < BANKS; b++) begin : g_bank
      assign bk_idle[b] = (bk_state[b] == BK_IDLE);
      assign bcmd[b] = '{
         act: acc && (cmd == CMD_ACT) && (pin_ff.ba == 2'(b)),
         rd: col_go && (cmd == CMD_RD) && (pin_ff.ba == 2'(b)),
         wr: col_go && (cmd == CMD_WR) && (pin_ff.ba == 2'(b)),
         pre: acc && (cmd == CMD_PRE) && (pin_ff.addr[AP_BIT] || (pin_ff.ba == 2'(b))),
         ap: pin_ff.addr[AP_BIT],
         done: bst_done[b],
         clear: dpd_go
      };
      lpbcs_bank u_bank (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cmd_i(bcmd[b]),
         .row_i(pin_ff.addr[ROW_W-1:0]),
         .state_o(bk_state[b]),
         .row_o(bk_row[b]),
         .col_ok_o(bk_col_ok[b])
      );
   end

   // ****************************************
   // Burst engine
   // ****************************************
   logic bst_act_ff, nxt_bst_act;
   logic bst_wr_ff, nxt_bst_wr;
   logic bst_ap_ff, nxt_bst_ap;
   logic [1:0] bst_bank_ff, nxt_bst_bank;
   logic [COL_W-1:0] bst_col_ff, nxt_bst_col;
   logic [4:0] bst_left_ff, nxt_bst_left;
   logic [1:0] bl_code_ff, nxt_bl_code;
   logic [4:0] bl_len;

   assign bl_len = 5'(5'h2 << bl_code_ff);
   assign bt_go = acc && (cmd == CMD_BT) && bst_act_ff && !bst_wr_ff && !bst_ap_ff;

   always_comb begin
      nxt_bst_act = bst_act_ff;
      nxt_bst_wr = bst_wr_ff;
      nxt_bst_ap = bst_ap_ff;
      nxt_bst_bank = bst_bank_ff;
      nxt_bst_col = bst_col_ff;
      nxt_bst_left = bst_left_ff;
      bst_done = '0;
      if (bst_act_ff) begin
         if (bst_left_ff <= 5'h1) begin
            nxt_bst_act = 1'b0;
            bst_done[bst_bank_ff] = 1'b1;
         end else begin
            nxt_bst_left = bst_left_ff - 5'h1;
            nxt_bst_col = bst_col_ff + 1'b1;
         end
         // Terminate leaves the row open since auto close was off
         if (bt_go) begin
            nxt_bst_act = 1'b0;
            bst_done[bst_bank_ff] = 1'b1;
         end
         if (bcmd[bst_bank_ff].pre) begin
            nxt_bst_act = 1'b0;
         end
      end
      if (col_go) begin
         // A new column command cuts the running burst short
         bst_done[bst_bank_ff] = bst_act_ff;
         bst_done[pin_ff.ba] = 1'b0;
         nxt_bst_act = 1'b1;
         nxt_bst_wr = (cmd == CMD_WR);
         nxt_bst_ap = pin_ff.addr[AP_BIT];
         nxt_bst_bank = pin_ff.ba;
         nxt_bst_col = pin_ff.addr[COL_W-1:0];
         nxt_bst_left = bl_len;
      end
      if (dpd_go) begin
         nxt_bst_act = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bst_act_ff <= 1'b0;
         bst_wr_ff <= 1'b0;
         bst_ap_ff <= 1'b0;
         bst_bank_ff <= 2'h0;
         bst_col_ff <= '0;
         bst_left_ff <= 5'h0;
      end else begin
         bst_act_ff <= nxt_bst_act;
         bst_wr_ff <= nxt_bst_wr;
         bst_ap_ff <= nxt_bst_ap;
         bst_bank_ff <= nxt_bst_bank;
         bst_col_ff <= nxt_bst_col;
         bst_left_ff <= nxt_bst_left;
      end
   end

   // ****************************************
   // Array and data path
   // ****************************************
   logic [DQ_W-1:0] mem [DEPTH];
   logic [DEPTH-1:0] vld_ff, nxt_vld;
   logic [IDX_W-1:0] idx;
   logic wr_beat;
   logic rd_beat;
   logic [DQ_W-1:0] nxt_dq;
   logic nxt_dq_oe;
   logic nxt_dqs;
   logic dq_oe_ff;
   logic dqs_ff;
   logic [DQ_W-1:0] dq_ff;

   assign idx = {bst_bank_ff, bk_row[bst_bank_ff], bst_col_ff};
   assign wr_beat = bst_act_ff && bst_wr_ff;
   assign rd_beat = bst_act_ff && !bst_wr_ff;

   // Byte lanes written only where the mask is low
   always_ff @(posedge clk_i) begin
      if (wr_beat && !pin_ff.dm[0]) begin
         mem[idx][7:0] <= pin_ff.dq[7:0];
      end
      if (wr_beat && !pin_ff.dm[1]) begin
         mem[idx][15:8] <= pin_ff.dq[15:8];
      end
   end

   // Deep power-down loses data; words read as zero until rewritten
   always_comb begin
      nxt_vld = vld_ff;
      if (wr_beat && (pin_ff.dm != 2'h3)) begin
         nxt_vld[idx] = 1'b1;
      end
      if (dpd_go) begin
         nxt_vld = '0;
      end
      nxt_dq = dq_ff;
      nxt_dq_oe = rd_beat;
      nxt_dqs = 1'b0;
      if (rd_beat) begin
         nxt_dq = vld_ff[idx] ? mem[idx] : '0;
         nxt_dqs = !dqs_ff;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vld_ff <= '0;
         dq_ff <= '0;
         dq_oe_ff <= 1'b0;
         dqs_ff <= 1'b0;
      end else begin
         vld_ff <= nxt_vld;
         dq_ff <= nxt_dq;
         dq_oe_ff <= nxt_dq_oe;
         dqs_ff <= nxt_dqs;
      end
   end

   assign mem_dq_o = dq_ff;
   assign mem_dq_oe_o = dq_oe_ff;
   assign mem_dqs_o = dqs_ff;
   assign mem_dqs_oe_o = dq_oe_ff;

   // ****************************************
   // Device mode and refresh
   // ****************************************
   logic [3:0] busy_ff, nxt_busy;
   logic [11:0] refcnt_ff, nxt_refcnt;
   logic quiet;

   assign quiet = all_idle && !bst_act_ff;

   always_comb begin
      nxt_md = md_ff;
      nxt_busy = busy_ff;
      nxt_refcnt = refcnt_ff;
      case (md_ff)
         MD_RUN: begin
            if (acc && (cmd == CMD_REF) && quiet) begin
               nxt_md = MD_BUSY;
               nxt_busy = RFC_CYC;
               nxt_refcnt = refcnt_ff + 12'h1;
            end else if (acc && (cmd == CMD_LMR) && quiet) begin
               nxt_md = MD_BUSY;
               nxt_busy = MRD_CYC;
            end else if (acc && (cmd == CMD_PRE) && pin_ff.addr[AP_BIT]) begin
               nxt_md = MD_BUSY;
               nxt_busy = RP_CYC;
            end else if (acc_low && (cmd == CMD_SREF) && quiet) begin
               nxt_md = MD_SELF;
               nxt_busy = RFC_CYC;
            end else if (dpd_go) begin
               nxt_md = MD_DEEP;
            end
         end
         MD_BUSY: begin
            if (busy_ff <= 4'h1) begin
               nxt_md = MD_RUN;
            end else begin
               nxt_busy = busy_ff - 4'h1;
            end
         end
         MD_SELF: begin
            // Inputs other than clock enable are ignored here
            if (busy_ff <= 4'h1) begin
               nxt_busy = RFC_CYC;
               nxt_refcnt = refcnt_ff + 12'h1;
            end else begin
               nxt_busy = busy_ff - 4'h1;
            end
            if (pin_ff.cke) begin
               nxt_md = MD_RUN;
            end
         end
         MD_DEEP: begin
            if (pin_ff.cke) begin
               nxt_md = MD_RUN;
            end
         end
         default: nxt_md = MD_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         md_ff <= MD_RUN;
         busy_ff <= 4'h0;
         refcnt_ff <= 12'h0;
      end else begin
         md_ff <= nxt_md;
         busy_ff <= nxt_busy;
         refcnt_ff <= nxt_refcnt;
      end
   end

   // ****************************************
   // Wishbone registers
   // ****************************************
   logic ack_ff, nxt_ack;
   logic [31:0] dat_ff, nxt_dat;
   logic [31:0] stat;

   for (genvar b = 0; b < BANKS; b++) begin : g_stat
      assign stat[3*b +: 3] = bk_state[b];
   end
   assign stat[STAT_MODE_LSB +: 3] = md_ff;
   assign stat[STAT_BURST_BIT] = bst_act_ff;
   assign stat[31:16] = 16'h0;

   always_comb begin
      nxt_ack = wb_cyc_i && wb_stb_i && !ack_ff;
      nxt_dat = 32'h0;
      nxt_bl_code = bl_code_ff;
      if (nxt_ack) begin
         if (wb_we_i && (wb_adr_i == REG_CTRL) && wb_sel_i[0]) begin
            nxt_bl_code = wb_dat_i[1:0];
         end
         case (wb_adr_i)
            REG_CTRL: nxt_dat = {30'h0, bl_code_ff};
            REG_STAT: nxt_dat = stat;
            REG_REFCNT: nxt_dat = {20'h0, refcnt_ff};
            default: nxt_dat = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_ff <= 1'b0;
         dat_ff <= 32'h0;
         bl_code_ff <= BL_CODE_RST;
      end else begin
         ack_ff <= nxt_ack;
         dat_ff <= nxt_dat;
         bl_code_ff <= nxt_bl_code;
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = dat_ff;

endmodule
`default_nettype wire

// ### lpbcs_ctl_model.sv
// Memory controller model that drives the command, mask and data pins.
// Assumes the bench calls one task at a time from a single process.
`timescale 1ns/1ps
`default_nettype none
module lpbcs_ctl_model import lpbcs_pkg::*; (
   // Clock
   input wire logic clk_i,
   // Pins, no strobe: the device owns it on reads
   output var lpbcs_pins_s pins_o
);
   // ****************************************
   // Drive tasks
   // ****************************************
   initial pins_o = PINS_IDLE;
   // Pattern is {cs_n, ras_n, cas_n, we_n}
   task automatic issue(input logic [3:0] p, input logic [1:0] ba, input logic [12:0] a, input logic ck);
      @(posedge clk_i);
      {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} <= p;
      pins_o.cke <= ck;
      pins_o.ba <= ba;
      pins_o.addr <= a;
   endtask
   // Every wait is spent deselected; released lines keep moving
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge clk_i);
         pins_o.cs_n <= 1'b1;
         pins_o.dq <= ~pins_o.dq;
         pins_o.ba <= ~pins_o.ba;
      end
   endtask
   task automatic beat(input logic [15:0] d, input logic [1:0] m);
      @(posedge clk_i);
      pins_o.cs_n <= 1'b1;
      pins_o.dq <= d;
      pins_o.dm <= m;
   endtask
endmodule
`default_nettype wire

// ### lpbcs_sva.sv
// Checker for the bank command block, bound to its top module.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module lpbcs_sva (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic [31:0] wb_dat_o,
   // Memory pins
   input wire logic mem_cs_n_i,
   input wire logic mem_ras_n_i,
   input wire logic mem_cas_n_i,
   input wire logic mem_we_n_i,
   input wire logic mem_cke_i,
   input wire logic mem_dq_oe_o,
   input wire logic mem_dqs_o,
   input wire logic mem_dqs_oe_o
);
   // ****************************************
   // Idle pattern counter
   // ****************************************
   logic [3:0] pat;
   logic [4:0] quiet_ff;
   logic [4:0] nxt_quiet;
   assign pat = {mem_cs_n_i, mem_ras_n_i, mem_cas_n_i, mem_we_n_i};
   // Saturates so a long idle spell never wraps
   always_comb begin
      nxt_quiet = quiet_ff;
      if (!pat[3] && pat != 4'h7) nxt_quiet = 5'h0;
      else if (quiet_ff != 5'h1f) nxt_quiet = quiet_ff + 5'h1;
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) quiet_ff <= 5'h0;
      else quiet_ff <= nxt_quiet;
   end
   // ****************************************
   // Properties
   // ****************************************
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("no ack after request");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   AST_DQS_OE: assert property (mem_dqs_oe_o == mem_dq_oe_o)
      else $error("strobe enable differs from data enable");
   AST_DQS_FIRST: assert property ($rose(mem_dq_oe_o) |-> mem_dqs_o)
      else $error("first strobe not high");
   AST_OE_FROM_READ: assert property ($rose(mem_dq_oe_o) |-> $past(pat, 4) == 4'h5 && $past(mem_cke_i, 4))
      else $error("data driven without read");
   AST_QUIET_END: assert property (quiet_ff >= 5'd22 |-> !mem_dq_oe_o)
      else $error("burst outlives longest length");
   AST_DEEP_CUT: assert property (pat == 4'h6 && !mem_cke_i && $past(mem_cke_i) |-> ##5 !mem_dq_oe_o [*3])
      else $error("data driven in deep power saving");
endmodule
bind lpbcs_top lpbcs_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .mem_cs_n_i(mem_cs_n_i), .mem_ras_n_i(mem_ras_n_i),
   .mem_cas_n_i(mem_cas_n_i), .mem_we_n_i(mem_we_n_i), .mem_cke_i(mem_cke_i), .mem_dq_oe_o(mem_dq_oe_o),
   .mem_dqs_o(mem_dqs_o), .mem_dqs_oe_o(mem_dqs_oe_o));
`default_nettype wire

// ### lpbcs_top_tb.sv
// Self-checking bench for the bank command block.
// Assumes the controller model and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module lpbcs_top_tb import lpbcs_pkg::*;;
   // ****************************************
   // Signals and helpers
   // ****************************************
   logic clk_i, rst_i, cyc, stb, we, ack, dq_oe, dqs, dqs_oe;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, wb_q;
   logic [15:0] dq_o, rnd;
   logic [15:0] bm [0:255];
   logic [1:0] rowv [0:3];
   lpbcs_pins_s pins;
   int fails, num_checks;
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   lpbcs_ctl_model u_ctl (.clk_i(clk_i), .pins_o(pins));
   lpbcs_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_q), .wb_ack_o(ack),
      .mem_cs_n_i(pins.cs_n), .mem_ras_n_i(pins.ras_n), .mem_cas_n_i(pins.cas_n), .mem_we_n_i(pins.we_n),
      .mem_cke_i(pins.cke), .mem_ba_i(pins.ba), .mem_addr_i(pins.addr), .mem_dm_i(pins.dm),
      .mem_dq_i(pins.dq), .mem_dq_o(dq_o), .mem_dq_oe_o(dq_oe), .mem_dqs_o(dqs), .mem_dqs_oe_o(dqs_oe));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [15:0] merge(input logic [15:0] o, n, input logic [1:0] m);
      return {m[1] ? o[15:8] : n[15:8], m[0] ? o[7:0] : n[7:0]};
   endfunction
   function automatic logic [11:0] banks(input logic [2:0] s0, s1, s2, s3);
      return {s3, s2, s1, s0};
   endfunction
   task automatic report_and_stop();
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = wb_q;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (n >= 20) begin
         fails++;
         report_and_stop();
      end
   endtask
   task automatic act(input logic [1:0] b, input logic [1:0] r);
      u_ctl.issue(4'h3, b, {11'h0, r}, 1'b1);
      rowv[b] = r;
      u_ctl.idle(5);
   endtask
   task automatic wr(input logic [1:0] b, input logic [3:0] c, input logic [1:0] m);
      logic [7:0] i;
      u_ctl.issue(4'h4, b, {9'h0, c}, 1'b1);
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         i = {b, rowv[b], 4'(c + 4'(k))};
         bm[i] = merge(bm[i], rnd, m);
         u_ctl.beat(rnd, m);
      end
   endtask
   task automatic rd(input logic [1:0] b, input logic [3:0] c, input logic ap, input int bl);
      int k;
      k = 0;
      u_ctl.issue(4'h5, b, {2'h0, ap, 6'h0, c}, 1'b1);
      repeat (bl + 8) begin
         u_ctl.idle(1);
         if (dq_oe === 1'b1 && k < bl) begin
            chk(dq_o, bm[{b, rowv[b], 4'(c + 4'(k))}]);
            k++;
         end
      end
      chk(k, bl);
   endtask
   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      int k;
      logic [31:0] r;
      {cyc, stb, we, adr, wdat} = '0;
      sel = 4'hf;
      rst_i = 1'b1;
      fails = 0;
      num_checks = 0;
      rnd = 16'h000f;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, REG_CTRL, 32'h0);
      chk(rdat, 32'(BL_CODE_RST));
      // Control write without byte lane 0 must be ignored
      sel <= 4'he;
      wb(1'b1, REG_CTRL, 32'h3);
      sel <= 4'hf;
      wb(1'b0, REG_CTRL, 32'h0);
      chk(rdat, 32'(BL_CODE_RST));
      wb(1'b1, REG_STAT, '1);
      wb(1'b0, 8'h0c, 32'h0);
      chk(rdat, 32'h0);
      u_ctl.issue(4'h7, 2'h0, 13'h0, 1'b1);
      u_ctl.idle(4);
      for (int b = 0; b < 4; b++) act(2'(b), 2'(3 - b));
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat, 32'(banks(BK_OPEN, BK_OPEN, BK_OPEN, BK_OPEN)));
      // Columns near the top on banks 0 to 2 exercise wrap within the burst; bank 3 starts at column 0
      for (int b = 0; b < 4; b++) begin
         wr(2'(b), 4'hd + 4'(b), 2'h0);
         wr(2'(b), 4'hd + 4'(b), rnd[1:0]);
         rd(2'(b), 4'hd + 4'(b), 1'b0, 4);
      end
      wb(1'b1, REG_CTRL, 32'h3);
      u_ctl.issue(4'h5, 2'h0, 13'h0, 1'b1);
      u_ctl.idle(3);
      u_ctl.issue(4'h6, 2'h3, 13'h0, 1'b1);
      k = 0;
      repeat (24) begin
         u_ctl.idle(1);
         if (dq_oe === 1'b1) k++;
      end
      chk(32'(k < 16), 32'h1);
      wb(1'b1, REG_CTRL, 32'(BL_CODE_RST));
      rd(2'h1, 4'he, 1'b1, 4);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat[11:0], banks(BK_OPEN, BK_IDLE, BK_OPEN, BK_OPEN));
      u_ctl.issue(4'h2, 2'h2, 13'h0, 1'b1);
      u_ctl.idle(5);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat[11:0], banks(BK_OPEN, BK_IDLE, BK_IDLE, BK_OPEN));
      u_ctl.issue(4'h2, 2'h2, 13'h400, 1'b1);
      u_ctl.idle(5);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat, 32'h0);
      wb(1'b0, REG_REFCNT, 32'h0);
      r = rdat;
      u_ctl.issue(4'h1, 2'h1, rnd[12:0], 1'b1);
      u_ctl.idle(12);
      wb(1'b0, REG_REFCNT, 32'h0);
      chk(rdat[11:0], r[11:0] + 12'h1);
      u_ctl.issue(4'h1, 2'h0, 13'h0, 1'b0);
      u_ctl.idle(5);
      u_ctl.issue(4'h3, 2'h0, 13'h0, 1'b0);
      u_ctl.idle(3);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat[14:0], {3'(MD_SELF), 12'h0});
      u_ctl.issue(4'h7, 2'h0, 13'h0, 1'b1);
      u_ctl.idle(5);
      act(2'h0, 2'h1);
      wr(2'h0, 4'h0, 2'h0);
      u_ctl.idle(8);
      u_ctl.issue(4'h2, 2'h0, 13'h400, 1'b1);
      u_ctl.idle(5);
      u_ctl.issue(4'h6, 2'h0, 13'h0, 1'b0);
      u_ctl.idle(5);
      wb(1'b0, REG_STAT, 32'h0);
      chk(rdat[14:12], 3'(MD_DEEP));
      u_ctl.issue(4'h7, 2'h0, 13'h0, 1'b1);
      u_ctl.idle(5);
      for (int i = 0; i < 4; i++) bm[{4'h1, 4'(i)}] = 16'h0;
      act(2'h0, 2'h1);
      rd(2'h0, 4'h0, 1'b0, 4);
      report_and_stop();
   end
endmodule
`default_nettype wire
